// >>> verilog/fer_defs.svh
// Purpose: Offsets, field positions, strap reset values and I/O addresses for the function enable register.
// Assumes: 40 MHz core clock, ISA I/O addresses of ten bits.
// Notes: Definitions only.
`ifndef FER_DEFS_SVH
`define FER_DEFS_SVH
`define CFG_IDX_ENABLE 8'h00
`define EN_LPT 0
`define EN_UART1 1
`define EN_UART2 2
`define EN_FLOPPY 3
`define EN_FOUR_DRIVE 4
`define EN_FLOPPY_SEC 5
`define EN_IDE 6
`define EN_IDE_SEC 7
`define RST_STRAP_00 8'h4b
`define RST_STRAP_10 8'h0f
`define RST_STRAP_11 8'h00
`define RST_STRAP_01 8'h00
`define FLOPPY_PRI_BASE 10'h3f0
`define FLOPPY_SEC_BASE 10'h370
`define FLOPPY_DOR_OFF 3'h2
`define IDE_PRI_BASE 10'h1f0
`define IDE_SEC_BASE 10'h170
`define IDE_PRI_CTL 10'h3f6
`define IDE_SEC_CTL 10'h376
`define CFG_INDEX_ADDR 10'h398
`define CFG_DATA_ADDR 10'h399
`endif

// >>> verilog/fer_pkg.sv
// Purpose: Types shared by the function enable register design.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only.
`default_nettype none
package fer_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [9:0] ioaddr_t;
    typedef enum logic [1:0] {ACC_IDLE, ACC_INDEXED, ACC_ARMED} cfg_acc_t;
endpackage : fer_pkg
`default_nettype wire

// >>> verilog/sync2.sv
// Purpose: Two flip-flop synchroniser for one pin level.
// Assumes: Asynchronous active-low reset.
// Notes: The first stage is read only by the second.
`default_nettype none
module sync2 (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// >>> verilog/floppy_pin_encode.sv
// Purpose: Drive select and motor pin encoding for two- or four-drive operation.
// Assumes: Output register value and write strobe come from the core clock domain.
// Notes: Pins are active low in two-drive mode.
`default_nettype none
module floppy_pin_encode (
    input wire logic four_drive,
    input wire logic [7:0] dor,
    input wire logic dor_wr_strobe,
    output logic drive_select_pin_a,
    output logic drive_select_pin_b,
    output logic motor_pin_a,
    output logic motor_pin_b
);
    wire [1:0] sel = dor[1:0];
    wire sel_motor = dor[3'd4 + {1'b0, sel}];
    wire two_ds_a = ~(sel == 2'd0);
    wire two_ds_b = ~(sel == 2'd1);
    // In four-drive mode the select bits go out raw and motor_pin_b carries the inverted write strobe.
    assign drive_select_pin_a = four_drive ? sel[0] : two_ds_a;
    assign drive_select_pin_b = four_drive ? sel[1] : two_ds_b;
    assign motor_pin_a = four_drive ? ~sel_motor : ~dor[4];
    assign motor_pin_b = four_drive ? ~dor_wr_strobe : ~dor[5];
endmodule : floppy_pin_encode
`default_nettype wire

// >>> verilog/function_enable_register.sv
// Functional notes
// - Disabled parallel, serial and floppy functions get clocks gated off; their register contents stay.
// - Parallel port decoded only while bit 0 is one.
// - Bit 1 decodes first serial port; clear blocks and powers it down.
// - Bit 2 decodes second serial port; clear blocks and powers it down.
// - Serial interrupts still reach their request pins after the port is disabled.
// - Bit 3 decodes floppy controller; clear blocks and powers it down.
// - Bit 4 picks direct two-drive pins or encoded four-drive pins.
// - Four-drive: select pins carry bits 1:0, motor_pin_a low when motor on.
// - Four-drive: motor_pin_b is an inverted write strobe to the output register.
// - Bit 5 picks floppy primary 3F0-7h or secondary range.
// - Bit 6 decodes IDE; clear idles selects, buffers and data bit 7.
// - Bit 7 picks IDE primary or secondary ranges.
// - Reset value taken from two straps; 01 is reserved.
//
// Purpose: Function enable register with its ISA index/data access and decode gating.
// Assumes: ISA strobes are synchronised here; IOW pulses last several clocks.
// Notes: Strap 01 is reserved and loads all zero.
`default_nettype none
`include "fer_defs.svh"
module function_enable_register (
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // ISA host bus.
    input wire fer_pkg::ioaddr_t SA,
    input wire fer_pkg::byte_t SD_IN,
    output fer_pkg::byte_t SD_OUT,
    output logic SD_OE_N,
    input wire logic IOW_N,
    input wire logic IOR_N,
    // Straps.
    input wire logic CONFIG_STRAP_A,
    input wire logic CONFIG_STRAP_B,
    // Power management control bit 0 from its own register.
    input wire logic PMC_IDE_TRISTATE,
    // Floppy output register value and serial interrupt sources.
    input wire fer_pkg::byte_t FLOPPY_DOR,
    input wire logic UART1_IRQ,
    input wire logic UART2_IRQ,
    // Decoded selects and clock enables to the peripherals, and the serial interrupt request pins.
    output logic LPT_SEL,
    output logic UART1_SEL,
    output logic UART2_SEL,
    output logic FLOPPY_SEL,
    output logic LPT_CLK_EN,
    output logic UART1_CLK_EN,
    output logic UART2_CLK_EN,
    output logic FLOPPY_CLK_EN,
    output logic UART1_IRQ_PIN,
    output logic UART2_IRQ_PIN,
    // Floppy drive pins.
    output logic DRIVE_SELECT_PIN_A,
    output logic DRIVE_SELECT_PIN_B,
    output logic MOTOR_PIN_A,
    output logic MOTOR_PIN_B,
    // IDE pins.
    output logic IDE_HOST_SELECT_A,
    output logic IDE_HOST_SELECT_A_OE_N,
    output logic IDE_HOST_SELECT_B,
    output logic IDE_HOST_SELECT_B_OE_N,
    output logic IDE_HIGH_BUFFER_ENABLE,
    output logic IDE_LOW_BUFFER_ENABLE,
    output logic IDE_DATA_BIT7_OE_N
);
    import fer_pkg::*;

    logic iow_s, ior_s, strap_a_s, strap_b_s;
    sync2 u_sync_iow (.CLK(CLK), .NRST(NRST), .d(~IOW_N), .q(iow_s));
    sync2 u_sync_ior (.CLK(CLK), .NRST(NRST), .d(~IOR_N), .q(ior_s));
    sync2 u_sync_sa (.CLK(CLK), .NRST(NRST), .d(CONFIG_STRAP_A), .q(strap_a_s));
    sync2 u_sync_sb (.CLK(CLK), .NRST(NRST), .d(CONFIG_STRAP_B), .q(strap_b_s));

    // Address is held stable over a strobe, so one stage of registering against the synced strobe suffices.
    ioaddr_t sa_r;
    byte_t sd_r;
    logic iow_d_r;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sa_r <= 10'h000;
            sd_r <= 8'h00;
            iow_d_r <= 1'b0;
        end else begin
            sa_r <= SA;
            sd_r <= SD_IN;
            iow_d_r <= iow_s;
        end
    end
    wire wr_pulse = iow_s & ~iow_d_r;
    wire hit_index = (sa_r == `CFG_INDEX_ADDR);
    wire hit_data = (sa_r == `CFG_DATA_ADDR);

    // Strap capture on the third edge after release, once the synchronisers are settled.
    logic [1:0] boot_cnt_r;
    logic strap_loaded_r;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            boot_cnt_r <= 2'd0;
        end else if (boot_cnt_r != 2'd3) begin
            boot_cnt_r <= boot_cnt_r + 2'd1;
        end
    end
    wire strap_load = (boot_cnt_r == 2'd2);
    byte_t strap_val;
    assign strap_val = ({strap_b_s, strap_a_s} == 2'b00) ? `RST_STRAP_00 :
                       ({strap_b_s, strap_a_s} == 2'b10) ? `RST_STRAP_10 :
                       ({strap_b_s, strap_a_s} == 2'b11) ? `RST_STRAP_11 : `RST_STRAP_01;

    // Index/data access sequencer.
    cfg_acc_t acc_r, acc_nxt;
    byte_t index_r, fer_r;
    always_comb begin
        acc_nxt = acc_r;
        if (wr_pulse) begin
            unique case (acc_r)
                ACC_IDLE: acc_nxt = hit_index ? ACC_INDEXED : ACC_IDLE;
                ACC_INDEXED: acc_nxt = hit_data ? ACC_ARMED : (hit_index ? ACC_INDEXED : ACC_IDLE);
                ACC_ARMED: acc_nxt = hit_index ? ACC_INDEXED : ACC_IDLE;
            endcase
        end else if (ior_s & (hit_index | hit_data)) begin
            // A read breaks a half-done pair but keeps the index, so read-modify-write needs no new index.
            acc_nxt = (acc_r == ACC_IDLE) ? ACC_IDLE : ACC_INDEXED;
        end
    end
    wire fer_wr = wr_pulse & hit_data & (acc_r == ACC_ARMED) & (index_r == `CFG_IDX_ENABLE);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            acc_r <= ACC_IDLE;
            index_r <= 8'h00;
            strap_loaded_r <= 1'b0;
            fer_r <= 8'h00;
        end else begin
            acc_r <= acc_nxt;
            if (wr_pulse & hit_index) begin
                index_r <= sd_r;
            end
            if (strap_load) begin
                fer_r <= strap_val;
                strap_loaded_r <= 1'b1;
            end else if (fer_wr) begin
                fer_r <= sd_r;
            end
        end
    end

    // Read data path.
    wire rd_any = ior_s & (hit_index | hit_data);
    byte_t rd_val;
    assign rd_val = hit_index ? index_r : ((index_r == `CFG_IDX_ENABLE) ? fer_r : 8'h00);
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SD_OUT <= 8'h00;
        end else begin
            SD_OUT <= rd_val;
        end
    end
    assign SD_OE_N = ~rd_any;

    // Decode gating. Parallel and serial address ranges live with those peripherals; floppy and IDE ranges are decoded here.
    wire en_lpt = fer_r[`EN_LPT];
    wire en_u1 = fer_r[`EN_UART1];
    wire en_u2 = fer_r[`EN_UART2];
    wire en_fd = fer_r[`EN_FLOPPY];
    wire en_ide = fer_r[`EN_IDE];
    wire fd_sec = fer_r[`EN_FLOPPY_SEC];
    wire ide_sec = fer_r[`EN_IDE_SEC];
    wire io_active = iow_s | ior_s;
    assign LPT_SEL = en_lpt & io_active;
    assign UART1_SEL = en_u1 & io_active;
    assign UART2_SEL = en_u2 & io_active;
    wire [9:0] fd_base = fd_sec ? `FLOPPY_SEC_BASE : `FLOPPY_PRI_BASE;
    wire fd_hit = (sa_r[9:3] == fd_base[9:3]);
    assign FLOPPY_SEL = en_fd & fd_hit & io_active;
    // Clocks stop but nothing is reset, so a re-enabled unit resumes with its old contents.
    assign LPT_CLK_EN = en_lpt;
    assign UART1_CLK_EN = en_u1;
    assign UART2_CLK_EN = en_u2;
    assign FLOPPY_CLK_EN = en_fd;
    // Interrupts bypass the enable; software must mask them first if it wants silence.
    assign UART1_IRQ_PIN = UART1_IRQ;
    assign UART2_IRQ_PIN = UART2_IRQ;

    // Floppy drive pins.
    wire dor_hit = fd_hit & (sa_r[2:0] == `FLOPPY_DOR_OFF);
    wire dor_strobe = en_fd & dor_hit & iow_s;
    floppy_pin_encode u_fpe (
        .four_drive(fer_r[`EN_FOUR_DRIVE]),
        .dor(FLOPPY_DOR),
        .dor_wr_strobe(dor_strobe),
        .drive_select_pin_a(DRIVE_SELECT_PIN_A),
        .drive_select_pin_b(DRIVE_SELECT_PIN_B),
        .motor_pin_a(MOTOR_PIN_A),
        .motor_pin_b(MOTOR_PIN_B)
    );

    // IDE decode and pins.
    wire [9:0] ide_base = ide_sec ? `IDE_SEC_BASE : `IDE_PRI_BASE;
    wire [9:0] ide_ctl = ide_sec ? `IDE_SEC_CTL : `IDE_PRI_CTL;
    wire ide_cmd_hit = (sa_r[9:3] == ide_base[9:3]);
    wire ide_ctl_hit = (sa_r[9:1] == ide_ctl[9:1]);
    wire ide_on = en_ide & io_active;
    assign IDE_HOST_SELECT_A = ~(ide_on & ide_cmd_hit);
    assign IDE_HOST_SELECT_B = ~(ide_on & ide_ctl_hit);
    assign IDE_HOST_SELECT_A_OE_N = ~en_ide & PMC_IDE_TRISTATE;
    assign IDE_HOST_SELECT_B_OE_N = ~en_ide & PMC_IDE_TRISTATE;
    assign IDE_HIGH_BUFFER_ENABLE = ~(ide_on & ide_cmd_hit);
    assign IDE_LOW_BUFFER_ENABLE = ~(ide_on & (ide_cmd_hit | ide_ctl_hit));
    assign IDE_DATA_BIT7_OE_N = ~(en_ide & ior_s & ide_ctl_hit & sa_r[0]);

    // Helper history for the write sequence checks.
    logic fer_wr_d_r;
    byte_t sd_d_r;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            fer_wr_d_r <= 1'b0;
            sd_d_r <= 8'h00;
        end else begin
            fer_wr_d_r <= fer_wr;
            sd_d_r <= sd_r;
        end
    end

    sequence s_index_write;
        wr_pulse & hit_index;
    endsequence
    sequence s_first_data;
        wr_pulse & hit_data & (acc_r == ACC_INDEXED);
    endsequence

    AST_DATA_TAKEN: assert property (@(posedge CLK) disable iff (!NRST)
        fer_wr_d_r & !strap_load |-> fer_r == sd_d_r)
        else $error("Second data write did not update the enable register.");
    AST_FIRST_WRITE_IGNORED: assert property (@(posedge CLK) disable iff (!NRST)
        wr_pulse & hit_data & (acc_r == ACC_INDEXED) & !strap_load |=> $stable(fer_r))
        else $error("Enable register changed on the first data write.");
    AST_ARMED_AFTER_INDEX: assert property (@(posedge CLK) disable iff (!NRST)
        s_first_data |=> acc_r == ACC_ARMED)
        else $error("First data write did not arm the sequencer.");
    AST_INDEX_STORED: assert property (@(posedge CLK) disable iff (!NRST)
        s_index_write |=> acc_r == ACC_INDEXED && index_r == $past(sd_r))
        else $error("Index write not stored.");
    AST_READ_KEEPS_INDEX: assert property (@(posedge CLK) disable iff (!NRST)
        ior_s & hit_data & (acc_r != ACC_IDLE) & !wr_pulse |=> acc_r == ACC_INDEXED)
        else $error("Data read lost the loaded index.");
    AST_OTHER_INDEX_IGNORED: assert property (@(posedge CLK) disable iff (!NRST)
        wr_pulse & hit_data & (index_r != `CFG_IDX_ENABLE) & !strap_load |=> $stable(fer_r))
        else $error("Enable register changed by a write to another index.");
    AST_STRAP_LOAD: assert property (@(posedge CLK) disable iff (!NRST)
        strap_load |=> fer_r == $past(strap_val) && strap_loaded_r)
        else $error("Strap value not loaded.");
    AST_STRAP_00: assert property (@(posedge CLK) disable iff (!NRST)
        strap_load & !strap_a_s & !strap_b_s |=> fer_r == 8'h4b)
        else $error("Strap 00 gave the wrong reset value.");
    AST_STRAP_10: assert property (@(posedge CLK) disable iff (!NRST)
        strap_load & !strap_a_s & strap_b_s |=> fer_r == `RST_STRAP_10)
        else $error("Strap 10 gave the wrong reset value.");
    AST_STRAP_11: assert property (@(posedge CLK) disable iff (!NRST)
        strap_load & strap_a_s & strap_b_s |=> fer_r == `RST_STRAP_11)
        else $error("Strap 11 gave the wrong reset value.");
    AST_LPT_BLOCK: assert property (@(posedge CLK) disable iff (!NRST)
        !fer_r[0] |-> !LPT_SEL)
        else $error("Parallel port selected while disabled.");
    AST_UART_BLOCK: assert property (@(posedge CLK) disable iff (!NRST)
        !fer_r[1] |-> !UART1_SEL && !UART1_CLK_EN)
        else $error("First serial port active while disabled.");
    AST_UART2_BLOCK: assert property (@(posedge CLK) disable iff (!NRST)
        !fer_r[2] |-> !UART2_SEL && !UART2_CLK_EN)
        else $error("Second serial port active while disabled.");
    AST_IRQ_PASS: assert property (@(posedge CLK) disable iff (!NRST)
        UART1_IRQ & !fer_r[1] |-> UART1_IRQ_PIN)
        else $error("Disabled serial port lost its interrupt.");
    AST_IRQ2_PASS: assert property (@(posedge CLK) disable iff (!NRST)
        UART2_IRQ & !fer_r[2] |-> UART2_IRQ_PIN)
        else $error("Disabled second serial port lost its interrupt.");
    AST_FLOPPY_RANGE: assert property (@(posedge CLK) disable iff (!NRST)
        FLOPPY_SEL |-> sa_r[9:3] == (fer_r[5] ? 7'h6e : 7'h7e))
        else $error("Floppy selected outside its range.");
    AST_FLOPPY_BLOCK: assert property (@(posedge CLK) disable iff (!NRST)
        !fer_r[3] |-> !FLOPPY_SEL && !FLOPPY_CLK_EN)
        else $error("Floppy controller active while disabled.");
    AST_FOUR_DRIVE_MOTOR: assert property (@(posedge CLK) disable iff (!NRST)
        fer_r[4] |-> MOTOR_PIN_A == !FLOPPY_DOR[3'd4 + {1'b0, FLOPPY_DOR[1:0]}])
        else $error("Encoded motor pin wrong.");
    AST_TWO_DRIVE_PINS: assert property (@(posedge CLK) disable iff (!NRST)
        !fer_r[4] |-> MOTOR_PIN_A == !FLOPPY_DOR[4] && MOTOR_PIN_B == !FLOPPY_DOR[5] &&
            DRIVE_SELECT_PIN_A == (FLOPPY_DOR[1:0] != 2'h0))
        else $error("Direct drive pins wrong.");
    AST_FOUR_DRIVE_SEL: assert property (@(posedge CLK) disable iff (!NRST)
        fer_r[4] |-> {DRIVE_SELECT_PIN_B, DRIVE_SELECT_PIN_A} == FLOPPY_DOR[1:0])
        else $error("Encoded drive select pins wrong.");
    AST_FOUR_DRIVE_STROBE: assert property (@(posedge CLK) disable iff (!NRST)
        fer_r[4] & fer_r[3] & iow_s & dor_hit |-> !MOTOR_PIN_B)
        else $error("Write strobe image missing on motor_pin_b.");
    AST_IDE_OFF: assert property (@(posedge CLK) disable iff (!NRST)
        !fer_r[6] |-> IDE_HIGH_BUFFER_ENABLE && IDE_LOW_BUFFER_ENABLE && IDE_DATA_BIT7_OE_N)
        else $error("IDE buffers active while disabled.");
    AST_IDE_PINS_IDLE: assert property (@(posedge CLK) disable iff (!NRST)
        !fer_r[6] |-> IDE_HOST_SELECT_A && IDE_HOST_SELECT_B &&
            (IDE_HOST_SELECT_A_OE_N == PMC_IDE_TRISTATE) && (IDE_HOST_SELECT_B_OE_N == PMC_IDE_TRISTATE))
        else $error("IDE host selects not idle while disabled.");
    AST_IDE_RANGE: assert property (@(posedge CLK) disable iff (!NRST)
        !IDE_HOST_SELECT_A |-> sa_r[9:3] == (fer_r[7] ? 7'h2e : 7'h3e))
        else $error("IDE selected outside its range.");
endmodule : function_enable_register
`default_nettype wire

// >>> sim/drive_decoder_model.sv
// Purpose: External four-drive decoder that sits on the encoded floppy pins.
// Assumes: The encoded drive and motor pins are valid only while four-drive mode is set.
// Notes: An unknown pin state selects no drive and no motor.
`default_nettype none
module drive_decoder_model (
    // Encoded pins.
    input wire logic ds_a,
    input wire logic ds_b,
    input wire logic mot_a,
    // Decoded result.
    output logic [1:0] drive,
    output logic motor_on,
    output logic valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // The real decoder would enable junk on a floating pin, so the model refuses it.
    assign valid = (^{ds_b, ds_a, mot_a} !== 1'bx);
    assign drive = valid ? {ds_b, ds_a} : 2'h0;
    assign motor_on = valid & ~mot_a;
endmodule : drive_decoder_model
`default_nettype wire

// >>> sim/function_enable_register_tb.sv
// Purpose: Self-checking bench for the function enable register.
// Assumes: Inputs change on the falling clock edge; ISA strobes are held six cycles.
// Notes: Select outputs are sampled late in each strobe, after the synchroniser lag.
`default_nettype none
`include "fer_defs.svh"
module function_enable_register_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fer_pkg::*;
    logic clk = 0, nrst = 0, iow_n = 1, ior_n = 1, strap_a = 0, strap_b = 0, pmc_tri = 0, irq1 = 0, irq2 = 0;
    ioaddr_t sa = 10'h000;
    byte_t sd_in = 8'h00, dor = 8'h00, sd_out, rd;
    logic sd_oe_n, lpt_sel, u1_sel, u2_sel, fl_sel, lpt_ce, u1_ce, u2_ce, fl_ce, u1_pin, u2_pin;
    logic ds_a, ds_b, mt_a, mt_b, hs_a, hs_a_oe_n, hs_b, hs_b_oe_n, hi_be, lo_be, d7_oe_n;
    logic [1:0] dec_drive;
    logic dec_motor, dec_valid;
    logic [6:0] snap;
    byte_t strap_val [3] = '{`RST_STRAP_11, `RST_STRAP_10, `RST_STRAP_00};
    logic [1:0] strap_sel [3] = '{2'h3, 2'h2, 2'h0};
    int mismatches = 0, checks = 0;

    function_enable_register u_dut (
        .CLK(clk), .NRST(nrst), .SA(sa), .SD_IN(sd_in), .SD_OUT(sd_out), .SD_OE_N(sd_oe_n),
        .IOW_N(iow_n), .IOR_N(ior_n), .CONFIG_STRAP_A(strap_a), .CONFIG_STRAP_B(strap_b),
        .PMC_IDE_TRISTATE(pmc_tri), .FLOPPY_DOR(dor), .UART1_IRQ(irq1), .UART2_IRQ(irq2),
        .LPT_SEL(lpt_sel), .UART1_SEL(u1_sel), .UART2_SEL(u2_sel), .FLOPPY_SEL(fl_sel),
        .LPT_CLK_EN(lpt_ce), .UART1_CLK_EN(u1_ce), .UART2_CLK_EN(u2_ce), .FLOPPY_CLK_EN(fl_ce),
        .UART1_IRQ_PIN(u1_pin), .UART2_IRQ_PIN(u2_pin), .DRIVE_SELECT_PIN_A(ds_a),
        .DRIVE_SELECT_PIN_B(ds_b), .MOTOR_PIN_A(mt_a), .MOTOR_PIN_B(mt_b),
        .IDE_HOST_SELECT_A(hs_a), .IDE_HOST_SELECT_A_OE_N(hs_a_oe_n), .IDE_HOST_SELECT_B(hs_b),
        .IDE_HOST_SELECT_B_OE_N(hs_b_oe_n), .IDE_HIGH_BUFFER_ENABLE(hi_be),
        .IDE_LOW_BUFFER_ENABLE(lo_be), .IDE_DATA_BIT7_OE_N(d7_oe_n)
    );
    drive_decoder_model u_decoder (
        .ds_a(ds_a), .ds_b(ds_b), .mot_a(mt_a), .drive(dec_drive), .motor_on(dec_motor), .valid(dec_valid)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // Address settles a cycle before the strobe and holds until after it is released.
    task automatic io(input logic wr, input ioaddr_t a, input byte_t d);
        @(negedge clk);
        sa = a;
        sd_in = d;
        @(negedge clk);
        if (wr) iow_n = 0;
        else ior_n = 0;
        repeat (6) @(negedge clk);
        rd = sd_out;
        snap = {sd_oe_n, lpt_sel, u1_sel, u2_sel, fl_sel, hs_a, mt_b};
        iow_n = 1;
        ior_n = 1;
        repeat (3) @(negedge clk);
    endtask : io

    task automatic cfg_wr(input byte_t idx, input byte_t d);
        io(1, `CFG_INDEX_ADDR, idx);
        io(1, `CFG_DATA_ADDR, d);
        io(1, `CFG_DATA_ADDR, d);
    endtask : cfg_wr

    task automatic cfg_rd(input byte_t idx);
        io(1, `CFG_INDEX_ADDR, idx);
        io(0, `CFG_DATA_ADDR, 8'h00);
    endtask : cfg_rd

    task automatic do_reset(input logic [1:0] s);
        {strap_b, strap_a} = s;
        nrst = 0;
        repeat (12) @(negedge clk);
        nrst = 1;
        repeat (6) @(negedge clk);
    endtask : do_reset

    task automatic end_test(input string name);
        $display("Test %s done, checks %0d, mismatches %0d", name, checks, mismatches);
    endtask : end_test

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    initial begin
        #500000;
        mismatches++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 3; i++) begin
            do_reset(strap_sel[i]);
            cfg_rd(`CFG_IDX_ENABLE);
            check(rd, strap_val[i], "strap reset value");
            check({fl_ce, u2_ce, u1_ce, lpt_ce}, strap_val[i][3:0], "clock enables");
            check(snap[6], 1'b0, "read drives data bus");
            check(sd_oe_n, 1'b1, "data bus released");
        end
        end_test("straps");
        io(1, `CFG_INDEX_ADDR, 8'h00);
        io(1, `CFG_DATA_ADDR, 8'h0e);
        cfg_rd(`CFG_IDX_ENABLE);
        check(rd, 8'h4b, "single data write");
        cfg_wr(8'h01, 8'h00);
        cfg_rd(`CFG_IDX_ENABLE);
        check(rd, 8'h4b, "other index write");
        cfg_wr(`CFG_IDX_ENABLE, 8'h0e);
        cfg_rd(`CFG_IDX_ENABLE);
        check(rd, 8'h0e, "double data write");
        check({fl_ce, u2_ce, u1_ce, lpt_ce}, 8'he, "clock enables");
        io(1, `CFG_DATA_ADDR, 8'h0c);
        io(1, `CFG_DATA_ADDR, 8'h0c);
        cfg_rd(`CFG_IDX_ENABLE);
        check(rd, 8'h0c, "write pair after read");
        end_test("access");
        for (int p = 0; p < 2; p++) begin
            cfg_wr(`CFG_IDX_ENABLE, p ? 8'h00 : 8'h0f);
            io(0, `FLOPPY_PRI_BASE, 8'h00);
            check(snap[5:2], p ? 4'h0 : 4'hf, "peripheral selects");
        end
        irq1 = 1;
        repeat (4) @(negedge clk);
        check({u1_pin, u2_pin}, 2'b10, "irq while disabled");
        irq1 = 0;
        irq2 = 1;
        repeat (4) @(negedge clk);
        check({u1_pin, u2_pin}, 2'b01, "irq while disabled");
        end_test("enables");
        for (int b = 0; b < 2; b++) begin
            cfg_wr(`CFG_IDX_ENABLE, b ? 8'h28 : 8'h08);
            for (int i = 0; i < 2; i++) begin
                io(0, i ? `FLOPPY_SEC_BASE : `FLOPPY_PRI_BASE, 8'h00);
                check(snap[2], b == i, "floppy range");
            end
            cfg_wr(`CFG_IDX_ENABLE, b ? 8'hc0 : 8'h40);
            for (int i = 0; i < 2; i++) begin
                io(0, i ? `IDE_SEC_BASE : `IDE_PRI_BASE, 8'h00);
                check(snap[1], b != i, "ide range");
            end
        end
        cfg_wr(`CFG_IDX_ENABLE, 8'h00);
        for (int t = 0; t < 2; t++) begin
            pmc_tri = t[0];
            repeat (3) @(negedge clk);
            check({hs_a_oe_n, hs_b_oe_n, hi_be, lo_be, d7_oe_n, pmc_tri | hs_a, pmc_tri | hs_b},
                  {t[0], t[0], 5'h1f}, "ide idle pins");
        end
        end_test("ranges");
        cfg_wr(`CFG_IDX_ENABLE, 8'h18);
        for (int d = 0; d < 4; d++) begin
            for (int m = 0; m < 2; m++) begin
                dor = 8'(m << (4 + d)) | 8'(d);
                repeat (3) @(negedge clk);
                check({ds_b, ds_a, mt_a}, {d[1:0], ~m[0]}, "encoded pins");
                check({dec_valid, dec_drive, dec_motor}, {1'b1, d[1:0], m[0]}, "decoded drive");
            end
        end
        check(mt_b, 1'b1, "motor_pin_b idle high");
        io(1, `FLOPPY_PRI_BASE + 10'h002, 8'h00);
        check(snap[0], 1'b0, "latch pulse on output register write");
        io(1, `FLOPPY_PRI_BASE + 10'h004, 8'h00);
        check(snap[0], 1'b1, "no pulse elsewhere");
        cfg_wr(`CFG_IDX_ENABLE, 8'h38);
        io(1, `FLOPPY_SEC_BASE + 10'h002, 8'h00);
        check(snap[0], 1'b0, "latch pulse at secondary address");
        cfg_wr(`CFG_IDX_ENABLE, 8'h08);
        dor = 8'h10;
        repeat (3) @(negedge clk);
        check({ds_b, ds_a, mt_b, mt_a}, 4'b1010, "direct drive and motor pins");
        end_test("floppy pins");
        close_out();
    end
endmodule : function_enable_register_tb
`default_nettype wire
